// ### rtl/wcs_pkg.sv
/*
  Constants and types for the writeable control store.
  Assumes one 200 MHz clock; widths are fixed at elaboration.
*/
package wcs_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned WORD_W      = 96;
  localparam int unsigned WORD_W_MIN  = 64;
  localparam int unsigned WORD_W_MAX  = 96;
  localparam int unsigned HOST_W      = 16;
  localparam int unsigned DEPTH       = 1 << ADDR_W;
  localparam int unsigned LANES       = WORD_W / HOST_W;
  localparam int unsigned LANE_W      = 3;

  // ==========================================================
  // Reset values and steps
  localparam logic [ADDR_W-1:0] PC_RESET   = 10'h000;
  localparam logic [ADDR_W-1:0] PC_STEP    = 10'h001;
  localparam logic [ADDR_W-1:0] WADDR_RESET = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 96'h0;
  localparam logic [LANE_W-1:0] LANE_LAST  = 3'h5;

  // ==========================================================
  // Store address source
  typedef enum logic [0:0]
  {
    SRC_SEQ  = 1'b0,
    SRC_HOST = 1'b1
  } addr_src_t;

endpackage : wcs_pkg

// ### rtl/wcs_store.sv
/*
  Writeable microprogram control store: sequencer read side with
  counter and instruction register, host load side with its own
  write-address and write-data registers, one shared memory.
  Assumes the host presents synchronous strobes on ref_clk.
*/
// Behaviour
// - Counter holds next address, advances by one
// - Instruction register holds executing microword
// - Separate write-data register holds load word
// - Separate write-address register for loads
// - Load pair independent of sequencing pair
// - Separate write and read data paths
// - Sequencer addresses reads, host addresses writes
// - Read output is one wide microword
// - Host loads word in narrow lanes
// - Microword bits drive resources undecoded
// - Address mux picks counter or host address
`timescale 1ns/100ps

module wcs_store
  import wcs_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Sequencer side
  input  wire logic              seq_step,
  input  wire logic              seq_load,
  input  wire logic [ADDR_W-1:0] seq_addr,
  output logic                   seq_stall,
  output logic [ADDR_W-1:0]      pc_value,
  output logic [WORD_W-1:0]      ctrl_word,
  output logic                   ctrl_valid,
  // Host load side
  input  wire logic              host_addr_we,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic              host_data_we,
  input  wire logic [LANE_W-1:0] host_lane,
  input  wire logic [HOST_W-1:0] host_data,
  input  wire logic              host_commit,
  output logic                   host_busy,
  output logic [ADDR_W-1:0]      waddr_value
);

  // ==========================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n = rst_sync_ff;

  // ==========================================================
  // Storage
  logic [WORD_W-1:0] mem [DEPTH];

  logic [ADDR_W-1:0] pc_ff;
  logic [ADDR_W-1:0] nxt_pc;
  logic [WORD_W-1:0] mir_ff;
  logic              mir_valid_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [WORD_W-1:0] wdata_ff;
  logic              commit_ff;
  addr_src_t         src;
  logic [ADDR_W-1:0] store_addr;

  // ==========================================================
  // Arbitration and address mux
  always_comb
  begin
    src = commit_ff ? SRC_HOST : SRC_SEQ;
    case (src)
      SRC_HOST: store_addr = waddr_ff;
      default:  store_addr = pc_ff;
    endcase
  end

  assign seq_stall = commit_ff & seq_step;
  assign host_busy = commit_ff;

  // ==========================================================
  // Microprogram counter
  always_comb
  begin
    nxt_pc = pc_ff;
    if (seq_load)
      nxt_pc = seq_addr;
    else if (seq_step && src == SRC_SEQ)
      nxt_pc = pc_ff + PC_STEP;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_ff <= PC_RESET;
    else if (src == SRC_SEQ || seq_load)
      pc_ff <= nxt_pc;
  end

  // ==========================================================
  // Microinstruction register, read path only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mir_ff       <= WORD_RESET;
      mir_valid_ff <= 1'b0;
    end
    else if (seq_step && src == SRC_SEQ && !seq_load)
    begin
      mir_ff       <= mem[store_addr];
      mir_valid_ff <= 1'b1;
    end
  end

  // Each bit goes straight to a machine resource
  assign ctrl_word  = mir_ff;
  assign ctrl_valid = mir_valid_ff;
  assign pc_value   = pc_ff;

  // ==========================================================
  // Write-address register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      waddr_ff <= WADDR_RESET;
    else if (host_addr_we && !commit_ff)
      waddr_ff <= host_addr;
  end

  assign waddr_value = waddr_ff;

  // ==========================================================
  // Write-data register, filled one host lane at a time
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          wdata_ff[g*HOST_W +: HOST_W] <= '0;
        else if (host_data_we && host_lane == LANE_W'(g))
          wdata_ff[g*HOST_W +: HOST_W] <= host_data;
      end
    end
  endgenerate

  // ==========================================================
  // Commit: one store write cycle, ahead of any sequencer read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      commit_ff <= 1'b0;
    else
      commit_ff <= host_commit && !commit_ff;
  end

  // Write port reads only the data register, never the read bus
  always_ff @(posedge ref_clk)
  begin
    if (commit_ff)
      mem[store_addr] <= wdata_ff;
  end

endmodule : wcs_store

// ### verif/wcs_host_model.sv
/* Host loader model for the control store.
   Assumes the bench calls load() just after a ref_clk rising edge. */
`timescale 1ns/100ps
module wcs_host_model
  import wcs_pkg::*;
(
  input  wire logic        ref_clk,
  output logic              host_addr_we = 1'b0,
  output logic [ADDR_W-1:0] host_addr = 10'h3FF,
  output logic              host_data_we = 1'b0,
  output logic [LANE_W-1:0] host_lane = 3'h0,
  output logic [HOST_W-1:0] host_data = 16'hFFFF,
  output logic              host_commit = 1'b0
);
  // ==========================================================
  // One microword, six lanes; released lines flip so no stale value lingers
  task automatic load(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w);
    host_addr_we = 1'b1;
    host_addr = a;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk) #1 host_addr_we = 1'b0;
      host_addr = ~a;
      host_data_we = 1'b1;
      host_lane = i[LANE_W-1:0];
      host_data = w[16*i+:16];
    end
    @(posedge ref_clk) #1 host_data_we = 1'b0;
    host_data = ~host_data;
    host_commit = 1'b1;
    @(posedge ref_clk) #1 host_commit = 1'b0;
    @(posedge ref_clk) #1;
  endtask : load
endmodule : wcs_host_model

// ### verif/wcs_store_assertions.sv
/* Port-level checks of the control store.
   Assumes it is bound onto wcs_store. */
`timescale 1ns/100ps
module wcs_store_assertions
  import wcs_pkg::*;
(
  input wire logic ref_clk, reset_n, seq_step, seq_load, seq_stall, ctrl_valid,
  input wire logic host_addr_we, host_commit, host_busy,
  input wire logic [ADDR_W-1:0] seq_addr, pc_value, host_addr, waddr_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire take = seq_step && !host_busy && !seq_load;
  chk_pc_advance: assert property (take |=> pc_value == $past(pc_value) + 1)
    else $error("pc did not advance");
  chk_word_valid: assert property (take |=> ctrl_valid)
    else $error("no valid word");
  chk_waddr_load: assert property (host_addr_we && !host_busy |=> waddr_value == $past(host_addr))
    else $error("write address not loaded");
  chk_waddr_held: assert property (!host_addr_we |=> $stable(waddr_value))
    else $error("write address moved");
  chk_pc_jump: assert property (seq_load |=> pc_value == $past(seq_addr))
    else $error("jump not taken");
  chk_stall_flag: assert property (seq_stall == (seq_step && host_busy))
    else $error("stall flag wrong");
  chk_stall_hold: assert property (seq_stall && !seq_load |=> $stable(pc_value))
    else $error("pc moved on stall");
  chk_busy_once: assert property (host_commit && !host_busy |=> host_busy ##1 !host_busy)
    else $error("busy not one cycle");
  cover property (seq_stall);
  cover property (host_busy);
  cover property (seq_load);
endmodule : wcs_store_assertions
bind wcs_store wcs_store_assertions chk (.*);

// ### verif/wcs_store_tb.sv
/* Self-checking bench for the control store.
   Assumes wcs_host_model as the loading host. */
`timescale 1ns/100ps
module wcs_store_tb;
  import wcs_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, seq_step = 1'b0, seq_load = 1'b0;
  logic [ADDR_W-1:0] seq_addr = 10'h000, pc_value, waddr_value, host_addr;
  logic [WORD_W-1:0] ctrl_word, exp_mem [16], q [$];
  logic [LANE_W-1:0] host_lane;
  logic [HOST_W-1:0] host_data, rnd = 16'h003A;
  logic seq_stall, ctrl_valid, host_busy, host_addr_we, host_data_we, host_commit;
  int mismatches = 0, checks_done = 0;
  wcs_store uut (.*);
  wcs_host_model host (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  // ==========================================================
  task automatic cmp(input logic [WORD_W-1:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [15:0] lfsr();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction : lfsr
  // Jump, then hold step until n reads have been taken
  task automatic run(input logic [ADDR_W-1:0] a, input int n);
    logic stalled;
    seq_load = 1'b1;
    seq_addr = a;
    @(posedge ref_clk) #1 seq_load = 1'b0;
    seq_step = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      q.push_back(exp_mem[a+i]);
      // Busy is settled here, so it tells whether the coming edge takes the step
      do
      begin
        stalled = host_busy;
        @(posedge ref_clk) #1;
      end
      while (stalled);
    end
    seq_step = 1'b0;
    cmp(WORD_W'(pc_value), WORD_W'(a + n));
    cmp(WORD_W'(ctrl_valid), WORD_W'(1));
  endtask : run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk)
    if (seq_step === 1'b1 && seq_stall === 1'b0 && seq_load === 1'b0)
    begin
      #2 cmp(ctrl_word, q.pop_front());
    end
  initial
  begin
    #20000 mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 cmp(ctrl_word, WORD_RESET);
    cmp(WORD_W'(ctrl_valid), WORD_W'(0));
    cmp(WORD_W'(waddr_value), WORD_W'(WADDR_RESET));
    $display("reset values done");
    for (int a = 0; a < 16; a++)
      exp_mem[a] = {lfsr(), lfsr(), lfsr(), lfsr(), lfsr(), lfsr()};
    for (int a = 0; a < 4; a++)
    begin
      host.load(a[ADDR_W-1:0], exp_mem[a]);
      cmp(WORD_W'(waddr_value), WORD_W'(a));
    end
    run(10'h000, 4);
    $display("load and read done");
    fork
      host.load(10'h009, exp_mem[9]);
      begin
        // Start late so a read falls on the store write cycle and stalls
        repeat (6) @(posedge ref_clk);
        #1 run(10'h000, 4);
      end
    join
    $display("read during load done");
    run(10'h009, 1);
    $display("jump read done");
    print_verdict();
  end
endmodule : wcs_store_tb
